// [hdl/hdsync_gen.sv]
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ns
module hdsync_gen
	import hdsync_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [15:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic [15:0]                 reg_rdata,
	input  wire logic [3*PIX_W-1:0]     pix_in_data,
	input  wire logic                   pix_in_valid,
	output logic                        pix_in_ready,
	output logic [3*PIX_W-1:0]          pix_out_data,
	output logic                        pix_out_valid,
	input  wire logic                   pix_out_ready,
	output logic                        hd_hsync_or_csync_out,
	output logic                        hd_vsync_out
);
	import hdsync_pkg::*;

	logic [CNT_W+SEQ_AW-1:0]       seq_tab   [SEQ_DEPTH];
	logic [LTYPE_PW*LTYPE_PTRS-1:0] ltype_tab [LTYPE_DEPTH];
	logic [(DUR_W+LVL_W)*PAT_PAIRS-1:0] pat_tab [PAT_DEPTH];
	logic [15:0]                   val_tab   [VAL_DEPTH];
	logic [7:0]                    ctrl;
	logic [XY_W-1:0]               width;
	logic [XY_W-1:0]               height;
	logic [XY_W-1:0]               trig_x;
	logic [XY_W-1:0]               trig_y;
	logic [XY_W-1:0]               cnt_x;
	logic [XY_W-1:0]               cnt_y;
	hdsync_state_type              state;
	logic [SEQ_AW-1:0]             seq_idx;
	logic [CNT_W-1:0]              line_rep;
	logic [2:0]                    ptr_idx;
	logic [PAT_PAIRW-1:0]          pair_idx;
	logic [DUR_W-1:0]              dur_cnt;
	logic                          dur_load;
	logic [DUR_W-1:0]              cur_dur;
	logic                          trig;
	logic                          step;
	logic [3:0]                    cur_type;
	logic [LTYPE_PW-1:0]           cur_pat;
	logic [DUR_W+LVL_W-1:0]        cur_pair;
	logic [LVL_W-1:0]              cur_lvl;
	logic [15:0]                   cur_val;
	logic                          last_pair;
	logic                          last_ptr;
	logic [PIX_W-1:0]              smooth_lvl;
	logic [PIX_W-1:0]              next_lvl;
	logic                          g_only;
	logic [3*PIX_W-1:0]            fifo_data;
	logic                          fifo_valid;
	logic                          fire;
	logic                          run;

	// register writes; table contents load straight from the port
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ctrl   <= '0;
			width  <= RST_WIDTH;
			height <= RST_HEIGHT;
			trig_x <= '0;
			trig_y <= '0;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				ADDR_CTRL:   ctrl   <= reg_wdata[7:0];
				ADDR_WIDTH:  width  <= reg_wdata[XY_W-1:0];
				ADDR_HEIGHT: height <= reg_wdata[XY_W-1:0];
				ADDR_TRIG_X: trig_x <= reg_wdata[XY_W-1:0];
				ADDR_TRIG_Y: trig_y <= reg_wdata[XY_W-1:0];
				default:     ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < SEQ_DEPTH; gi++)
		begin : g_tab
			always_ff @(posedge core_clk)
			begin
				if (!rst_n)
					seq_tab[gi] <= '0;
				else if (reg_wr && reg_addr == ADDR_SEQ_BASE + 8'(gi))
					seq_tab[gi] <= reg_wdata[CNT_W+SEQ_AW-1:0];
			end
			// line type pointer lists, two words per entry
			always_ff @(posedge core_clk)
			begin
				if (!rst_n)
					ltype_tab[gi] <= '0;
				else if (reg_wr && reg_addr == ADDR_LT_BASE + 8'(2*gi))
					ltype_tab[gi][11:0] <= reg_wdata[11:0];
				else if (reg_wr && reg_addr == ADDR_LT_BASE + 8'(2*gi+1))
					ltype_tab[gi][23:12] <= reg_wdata[11:0];
			end
			if (gi < PAT_DEPTH)
			begin : g_pat
				// pattern pairs, one word per pair
				always_ff @(posedge core_clk)
				begin
					if (!rst_n)
						pat_tab[gi] <= '0;
					else
						for (int p = 0; p < PAT_PAIRS; p++)
							if (reg_wr && reg_addr == ADDR_PAT_BASE + 8'(4*gi+p))
								pat_tab[gi][p*13 +: 13] <= reg_wdata[12:0];
				end
				always_ff @(posedge core_clk)
				begin
					if (!rst_n)
						val_tab[gi] <= '0;
					else if (reg_wr && reg_addr == ADDR_VAL_BASE + 8'(gi))
						val_tab[gi] <= reg_wdata;
				end
			end
		end
	endgenerate

	// read data in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			if (reg_addr == ADDR_CTRL)
				reg_rdata <= {8'h00, ctrl};
			else if (reg_addr == ADDR_WIDTH)
				reg_rdata <= {4'h0, width};
			else if (reg_addr == ADDR_HEIGHT)
				reg_rdata <= {4'h0, height};
			else if (reg_addr == ADDR_TRIG_X)
				reg_rdata <= {4'h0, trig_x};
			else if (reg_addr == ADDR_TRIG_Y)
				reg_rdata <= {4'h0, trig_y};
			else if (reg_addr == ADDR_STATUS)
				reg_rdata <= {1'b0, pair_idx, ptr_idx, line_rep};
			else if (reg_addr >= ADDR_SEQ_BASE && reg_addr < ADDR_LT_BASE)
				reg_rdata <= {2'b00, seq_tab[reg_addr[3:0]]};
			else if (reg_addr >= ADDR_VAL_BASE && reg_addr < ADDR_VAL_END)
				reg_rdata <= val_tab[reg_addr[2:0]];
			else
				reg_rdata <= '0;
		end
		else
			reg_rdata <= '0;
	end

	// engine steps once per pixel that leaves the block
	assign run  = ctrl[CTRL_ENABLE];
	assign fire = fifo_valid && pix_out_ready;
	assign step = fire && run;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !run)
		begin
			cnt_x <= '0;
			cnt_y <= '0;
		end
		else if (step)
		begin
			if (cnt_x >= width - 1'b1)
			begin
				cnt_x <= '0;
				cnt_y <= (cnt_y >= height - 1'b1) ? '0 : cnt_y + 1'b1;
			end
			else
				cnt_x <= cnt_x + 1'b1;
		end
	end
	assign trig = step && cnt_x == trig_x && cnt_y == trig_y;

	// type 0 reads an empty entry
	assign cur_type  = seq_tab[seq_idx][3:0];
	assign cur_pat   = ltype_tab[cur_type][ptr_idx*LTYPE_PW +: LTYPE_PW];
	assign cur_pair  = pat_tab[cur_pat][pair_idx*13 +: 13];
	assign cur_lvl   = cur_pair[LVL_W-1:0];
	assign cur_val   = val_tab[cur_lvl[VAL_AW-1:0]];
	// a fresh pair takes its duration straight from the table
	assign cur_dur   = dur_load ? cur_pair[DUR_W+LVL_W-1:LVL_W] : dur_cnt;
	// an all-zero later pair, duration and level both zero, ends the pattern early
	assign last_pair = (pair_idx == 2'(PAT_PAIRS - 1)) ||
		(pat_tab[cur_pat][(pair_idx+2'd1)*13 +: 13] == '0);
	assign last_ptr  = (ptr_idx == 3'(LTYPE_PTRS - 1)) ||
		(ltype_tab[cur_type][(ptr_idx+3'd1)*LTYPE_PW +: LTYPE_PW] == '0);

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state    <= HDSYNC_IDLE;
			seq_idx  <= '0;
			line_rep <= '0;
			ptr_idx  <= '0;
			pair_idx <= '0;
			dur_cnt  <= '0;
			dur_load <= 1'b1;
		end
		else
		begin
			unique case (state)
				HDSYNC_IDLE:
				begin
					if (run)
						state <= HDSYNC_LOAD;
				end
				HDSYNC_LOAD, HDSYNC_RUN:
				begin
					if (!run)
						state <= HDSYNC_IDLE;
					else if (trig || state == HDSYNC_LOAD)
					begin
						state    <= HDSYNC_RUN;
						seq_idx  <= '0;
						line_rep <= '0;
						ptr_idx  <= '0;
						pair_idx <= '0;
						dur_load <= 1'b1;
					end
					else if (step)
					begin
						dur_load <= (cur_dur == '0);
						if (cur_dur != '0)
							dur_cnt <= cur_dur - 1'b1;
						else if (!last_pair)
							pair_idx <= pair_idx + 1'b1;
						else
						begin
							pair_idx <= '0;
							if (!last_ptr)
								ptr_idx <= ptr_idx + 1'b1;
							else
							begin
								ptr_idx <= '0;
								if (line_rep + 1'b1 < seq_tab[seq_idx][13:4])
									line_rep <= line_rep + 1'b1;
								else
								begin
									line_rep <= '0;
									seq_idx  <= (seq_idx == ctrl[7:4]) ? '0 : seq_idx + 1'b1;
								end
							end
						end
					end
				end
				default: state <= HDSYNC_IDLE;
			endcase
		end
	end

	// insertion point set by the tables, restarted at the trig_x, trig_y position of the video
	assign next_lvl = (state == HDSYNC_RUN) ? cur_val[PIX_W-1:0] : '0;
	assign g_only   = cur_lvl[LVL_G_ONLY];
	hdsync_smooth u_smooth (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.step      (step),
		.bypass    (!ctrl[CTRL_FILTER]),
		.level_in  (next_lvl),
		.level_out (smooth_lvl)
	);
	hdsync_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_data   (pix_in_data),
		.in_valid  (pix_in_valid),
		.in_ready  (pix_in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (pix_out_ready)
	);
	// output stage holds registered pixel and sync pins
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pix_out_data          <= '0;
			pix_out_valid         <= 1'b0;
			hd_hsync_or_csync_out <= 1'b0;
			hd_vsync_out          <= 1'b0;
		end
		else
		begin
			pix_out_valid <= fire;
			if (fire)
			begin
				// insert into G only or all three
				if (state == HDSYNC_RUN && cur_val[PIX_W-1:0] != '0)
					pix_out_data <= g_only ?
						{fifo_data[23:16], smooth_lvl, fifo_data[7:0]} :
						{smooth_lvl, smooth_lvl, smooth_lvl};
				else
					pix_out_data <= fifo_data;
				hd_hsync_or_csync_out <= (state == HDSYNC_RUN) && cur_val[VAL_HS_BIT];
				hd_vsync_out          <= (state == HDSYNC_RUN) && cur_val[VAL_VS_BIT];
			end
		end
	end
endmodule : hdsync_gen

// [hdl/hdsync_pkg.sv]
package hdsync_pkg;
	// geometry of the linked tables
	localparam int SEQ_DEPTH     = 16;
	localparam int SEQ_AW        = 4;
	localparam int LTYPE_DEPTH   = 16;
	localparam int LTYPE_PTRS    = 8;
	localparam int LTYPE_PW      = 3;
	localparam int PAT_DEPTH     = 8;
	localparam int PAT_PAIRS     = 4;
	localparam int PAT_PAIRW     = 2;
	localparam int VAL_DEPTH     = 8;
	localparam int VAL_AW        = 3;
	localparam int CNT_W         = 10;
	localparam int DUR_W         = 8;
	localparam int LVL_W         = 5;
	localparam int LVL_G_ONLY    = 4;
	localparam int PIX_W         = 8;
	localparam int XY_W          = 12;
	localparam int FIFO_DEPTH    = 4;
	localparam int FIFO_W        = 3 * PIX_W;
	localparam int FILT_SHIFT    = 1;
	// register map, word indices
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_WIDTH    = 8'h01;
	localparam logic [7:0] ADDR_HEIGHT   = 8'h02;
	localparam logic [7:0] ADDR_TRIG_X   = 8'h03;
	localparam logic [7:0] ADDR_TRIG_Y   = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h05;
	localparam logic [7:0] ADDR_SEQ_BASE = 8'h10;
	localparam logic [7:0] ADDR_LT_BASE  = 8'h20;
	localparam logic [7:0] ADDR_PAT_BASE = 8'h40;
	localparam logic [7:0] ADDR_VAL_BASE = 8'h80;
	localparam logic [7:0] ADDR_VAL_END  = 8'h88;
	// control fields
	localparam int CTRL_ENABLE   = 0;
	localparam int CTRL_FILTER   = 1;
	localparam int CTRL_SEQ_LAST = 4;
	// value entry digital pulse bits, low bits of second byte
	localparam int VAL_HS_BIT    = 8;
	localparam int VAL_VS_BIT    = 9;
	localparam logic [11:0] RST_WIDTH  = 12'h898;
	localparam logic [11:0] RST_HEIGHT = 12'h465;
	typedef enum logic [1:0] {
		HDSYNC_IDLE = 2'b00,
		HDSYNC_LOAD = 2'b01,
		HDSYNC_RUN  = 2'b10
	} hdsync_state_type;
endpackage : hdsync_pkg

// [hdl/hdsync_fifo.sv]
`timescale 1ns/1ns
module hdsync_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      fill;
	logic             push;
	logic             pop;

	assign in_ready  = (fill != DEPTH[AW:0]);
	assign out_valid = (fill != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : hdsync_fifo

// [hdl/hdsync_smooth.sv]
`timescale 1ns/1ns
module hdsync_smooth (
	input  wire logic                         core_clk,
	input  wire logic                         rst_n,
	input  wire logic                         step,
	input  wire logic                         bypass,
	input  wire logic [hdsync_pkg::PIX_W-1:0] level_in,
	output logic [hdsync_pkg::PIX_W-1:0]      level_out
);
	import hdsync_pkg::*;

	// first order low-pass on the inserted level; softens edges, no ringing
	logic [PIX_W-1:0] prev;
	logic [PIX_W:0]   sum;
	assign sum       = {1'b0, prev} + {1'b0, level_in};
	// combinational so the level belongs to the pixel being stepped, not the one before
	assign level_out = bypass ? level_in : sum[PIX_W:FILT_SHIFT];

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			prev <= '0;
		else if (step)
			prev <= level_out;
	end
endmodule : hdsync_smooth

// [verification/hdsync_gen_asserts.sv]
`timescale 1ns/1ns
module hdsync_gen_asserts (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        pix_in_valid,
	input wire logic        pix_in_ready,
	input wire logic        pix_out_valid,
	input wire logic        pix_out_ready,
	input wire logic        hd_hsync_or_csync_out,
	input wire logic        hd_vsync_out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data set outside answer");
	property p_out_cause;
		pix_out_valid |-> $past(pix_out_ready);
	endproperty
	a_out_cause: assert property (p_out_cause) else $error("pixel out without ready");
	property p_stalled;
		!pix_out_ready [*2] |-> !pix_out_valid;
	endproperty
	a_stalled: assert property (p_stalled) else $error("pixel out while stalled");
	property p_fills;
		(pix_in_valid && !pix_out_ready) [*5] |-> !pix_in_ready;
	endproperty
	a_fills: assert property (p_fills) else $error("buffer takes a fifth word");
	property p_stays_full;
		!pix_in_ready && !pix_out_ready |=> !pix_in_ready;
	endproperty
	a_stays_full: assert property (p_stays_full) else $error("full buffer freed");
	property p_fall;
		$fell(pix_in_ready) |-> $past(pix_in_valid);
	endproperty
	a_fall: assert property (p_fall) else $error("buffer filled without push");
	property p_rise;
		$rose(pix_in_ready) |-> $past(pix_out_ready);
	endproperty
	a_rise: assert property (p_rise) else $error("buffer drained without pop");
	// sync pins move only with an output pixel
	property p_sync_hold;
		!pix_out_valid |-> $stable(hd_hsync_or_csync_out) && $stable(hd_vsync_out);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync moved without pixel");
endmodule : hdsync_gen_asserts
bind hdsync_gen hdsync_gen_asserts u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
	.pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
	.hd_hsync_or_csync_out(hd_hsync_or_csync_out), .hd_vsync_out(hd_vsync_out)
);

// [verification/hdsync_monitor_model.sv]
`timescale 1ns/1ns
module hdsync_monitor_model (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        stall,
	input  wire logic [23:0] pix_out_data,
	input  wire logic        pix_out_valid,
	input  wire logic        hsync,
	input  wire logic        vsync,
	output logic             pix_out_ready
);
	logic [25:0] seen [$];
	initial pix_out_ready = 1'b0;
	// the display may stall, pixels are kept with their sync levels
	always @(posedge core_clk)
	begin
		pix_out_ready <= rst_n && !stall;
		if (rst_n && pix_out_valid === 1'b1)
			seen.push_back({vsync, hsync, pix_out_data});
	end
endmodule : hdsync_monitor_model

// [verification/tb_hdsync_gen.sv]
`timescale 1ns/1ns
module tb_hdsync_gen;
	import hdsync_pkg::*;
	logic        core_clk     = 1'b0;
	logic        rst_n        = 1'b0;
	logic [7:0]  reg_addr     = 8'h00;
	logic [15:0] reg_wdata    = 16'h0000;
	logic        reg_wr       = 1'b0;
	logic        reg_rd       = 1'b0;
	logic [23:0] pix_in_data  = 24'h112233;
	logic        pix_in_valid = 1'b0;
	logic        stall        = 1'b1;
	logic [15:0] reg_rdata;
	logic        pix_in_ready;
	logic [23:0] pix_out_data;
	logic        pix_out_valid;
	logic        pix_out_ready;
	logic        hs;
	logic        vs;
	int          mismatches   = 0;
	int          check_count  = 0;
	always #4 core_clk = ~core_clk;
	hdsync_gen DUT (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pix_in_data(pix_in_data), .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
		.pix_out_data(pix_out_data), .pix_out_valid(pix_out_valid),
		.pix_out_ready(pix_out_ready), .hd_hsync_or_csync_out(hs), .hd_vsync_out(vs)
	);
	hdsync_monitor_model u_mon (
		.core_clk(core_clk), .rst_n(rst_n), .stall(stall), .pix_out_data(pix_out_data),
		.pix_out_valid(pix_out_valid), .hsync(hs), .vsync(vs), .pix_out_ready(pix_out_ready)
	);
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// a gap cycle keeps each strobe a single assignment per step
	task wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask : rd
	task test_regs;
		logic [15:0] d;
		rd(ADDR_WIDTH, d);
		chk("width reset", RST_WIDTH, d);
		rd(ADDR_HEIGHT, d);
		chk("height reset", RST_HEIGHT, d);
		wr(8'h07, 16'hFFFF);
		rd(8'h07, d);
		chk("unmapped read", 0, d);
		$display("test_regs done");
	endtask : test_regs
	task test_fifo;
		int n;
		n = 0;
		pix_in_valid <= 1'b1;
		repeat (8)
		begin
			@(posedge core_clk);
			if (pix_in_ready === 1'b1)
				n++;
		end
		pix_in_valid <= 1'b0;
		stall <= 1'b0;
		repeat (12) @(posedge core_clk);
		chk("words taken", FIFO_DEPTH, n);
		chk("words out", FIFO_DEPTH, u_mon.seen.size());
		chk("idle pass", 24'h112233, u_mon.seen[0][23:0]);
		u_mon.seen.delete();
		$display("test_fifo done");
	endtask : test_fifo
	task test_engine;
		logic [25:0] e [3];
		int          i;
		e = '{{2'b10, 24'h113333}, {2'b01, 24'h555555}, {2'b01, 24'h555555}};
		wr(ADDR_VAL_BASE + 8'h01, 16'h0155);
		wr(ADDR_VAL_BASE + 8'h02, 16'h0233);
		// patterns go in before line types, durations minus one
		wr(ADDR_PAT_BASE + 8'h04, 16'h0021);
		wr(ADDR_PAT_BASE + 8'h05, 16'h0012);
		wr(ADDR_LT_BASE + 8'h02, 16'h0001);
		wr(ADDR_LT_BASE + 8'h03, 16'h0000);
		wr(ADDR_SEQ_BASE, 16'h0011);
		wr(ADDR_WIDTH, 16'h0003);
		wr(ADDR_HEIGHT, 16'h0002);
		wr(ADDR_TRIG_X, 16'h0000);
		wr(ADDR_TRIG_Y, 16'h0000);
		wr(ADDR_CTRL, 16'h0001);
		pix_in_valid <= 1'b1;
		repeat (40) @(posedge core_clk);
		pix_in_valid <= 1'b0;
		repeat (8) @(posedge core_clk);
		i = 3;
		while (i < 12 && u_mon.seen[i][23:0] !== 24'h113333)
			i++;
		for (int k = 0; k < 9; k++)
			chk("pixel", e[k % 3], u_mon.seen[i + k]);
		wr(ADDR_CTRL, 16'h0003);
		u_mon.seen.delete();
		pix_in_valid <= 1'b1;
		repeat (30) @(posedge core_clk);
		pix_in_valid <= 1'b0;
		repeat (8) @(posedge core_clk);
		// old and new level averaged per pixel: 0x41, 0x4B, 0x50 once settled
		e = '{{2'b10, 24'h114133}, {2'b01, 24'h4B4B4B}, {2'b01, 24'h505050}};
		i = 3;
		while (i < 12 && u_mon.seen[i][23:0] !== 24'h114133)
			i++;
		for (int k = 0; k < 6; k++)
			chk("filtered pixel", e[k % 3], u_mon.seen[i + k]);
		$display("test_engine done");
	endtask : test_engine
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	initial
	begin
		#100000;
		mismatches++;
		finish_test();
	end
	initial
	begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		test_regs();
		test_fifo();
		test_engine();
		finish_test();
	end
endmodule : tb_hdsync_gen
